// file: hw/ipr_core.sv
`timescale 1ns/100ps
// What this block does
// - With high crosstalk mode active the proximity result is cut to a 10-bit format.
// - High crosstalk mode is active only when both of its enable bits are set.
// - With sleep_after_irq set the oscillator is stopped while the interrupt pin is low.
// - A stop caused by sleep_after_irq sets the sleep_after_irq_flag status bit.
// - Bits 7:4 of pin_source_select choose what drives the interrupt pin.
// - Persistence filters limit the rate of proximity and light interrupts.
// - A proximity interrupt needs a programmed count of consecutive out-of-window results.
// - A proximity result inside the window resets the consecutive count to zero.
module ipr_core (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Register port
  input wire ipr_pkg::ipr_reg_req_s reg_req_in,
  output logic [7:0] reg_rdata_out,
  // Second enable bit of the crosstalk pair, held in another register
  input wire logic high_xtalk_enable_b_in,
  // Proximity engine
  input wire logic prox_valid_in,
  input wire logic [ipr_pkg::RESULT_W-1:0] proximity_result_in,
  input wire logic [ipr_pkg::RESULT_W-1:0] proximity_low_threshold_in,
  input wire logic [ipr_pkg::RESULT_W-1:0] proximity_high_threshold_in,
  // Light engine out-of-window sample strobe
  input wire logic light_valid_in,
  input wire logic light_out_of_range_in,
  // Interrupt clear strobes and emitter
  input wire logic clear_light_irq_in,
  input wire logic clear_proximity_irq_in,
  input wire logic clear_sleep_flag_in,
  input wire logic emitter_pulse_in,
  // Outputs
  output logic [ipr_pkg::RESULT_W-1:0] proximity_result_out,
  output logic light_irq_out,
  output logic proximity_irq_out,
  output logic irq_pin_n_out,
  output logic aux_pin_out,
  output logic osc_enable_out,
  output logic sleep_after_irq_flag_out
);
  logic [7:0] config_sleep_crosstalk;
  logic [7:0] pin_source_select;
  logic [7:0] interrupt_persistence;
  logic [ipr_pkg::INTERRUPT_PERSISTENCE_CNT_W-1:0] prox_cnt;
  logic [ipr_pkg::INTERRUPT_PERSISTENCE_CNT_W-1:0] light_cnt;
  logic [ipr_pkg::INTERRUPT_PERSISTENCE_CNT_W-1:0] next_prox_cnt;
  logic [ipr_pkg::INTERRUPT_PERSISTENCE_CNT_W-1:0] next_light_cnt;
  logic high_xtalk_active;
  logic sleep_after_irq;
  logic prox_out;
  logic irq_assert;
  logic aux_assert;
  logic normal_irq;
  ipr_pkg::ipr_irq_src_s src;

  assign high_xtalk_active = config_sleep_crosstalk[ipr_pkg::HIGH_XTALK_A_BIT]
                             && high_xtalk_enable_b_in;
  assign sleep_after_irq = config_sleep_crosstalk[ipr_pkg::SLEEP_AFTER_IRQ_BIT];
  assign normal_irq = light_irq_out || proximity_irq_out;
  assign src = '{light_irq: light_irq_out, proximity_irq: proximity_irq_out,
                 emitter_pulse: emitter_pulse_in};
  assign prox_out = (proximity_result_in < proximity_low_threshold_in)
                    || (proximity_result_in > proximity_high_threshold_in);

  // Registers; reserved bits keep their reset values
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      config_sleep_crosstalk <= ipr_pkg::RST_CONFIG_SLEEP_CROSSTALK;
      pin_source_select <= ipr_pkg::RST_PIN_SOURCE_SELECT;
      interrupt_persistence <= ipr_pkg::RST_INTERRUPT_PERSISTENCE;
    end else if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        ipr_pkg::ADDR_CONFIG_SLEEP_CROSSTALK: config_sleep_crosstalk <=
            (reg_req_in.wdata & ipr_pkg::CONFIG_SLEEP_CROSSTALK_RW_MASK)
            | (ipr_pkg::RST_CONFIG_SLEEP_CROSSTALK & ~ipr_pkg::CONFIG_SLEEP_CROSSTALK_RW_MASK);
        ipr_pkg::ADDR_PIN_SOURCE_SELECT: pin_source_select <= reg_req_in.wdata;
        ipr_pkg::ADDR_INTERRUPT_PERSISTENCE: interrupt_persistence <= reg_req_in.wdata;
        default: ;
      endcase
    end
  end

  // Read data, registered; unmapped addresses read zero
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        ipr_pkg::ADDR_CONFIG_SLEEP_CROSSTALK: reg_rdata_out <= config_sleep_crosstalk;
        ipr_pkg::ADDR_PIN_SOURCE_SELECT: reg_rdata_out <= pin_source_select;
        ipr_pkg::ADDR_INTERRUPT_PERSISTENCE: reg_rdata_out <= interrupt_persistence;
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // Proximity result, truncated in high crosstalk mode
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      proximity_result_out <= 16'h0000;
    end else if (prox_valid_in) begin
      if (high_xtalk_active) begin
        proximity_result_out <= {6'h00,
            proximity_result_in[ipr_pkg::XTALK_RESULT_W-1:0]};
      end else begin
        proximity_result_out <= proximity_result_in;
      end
    end
  end

  // Persistence counters; a count of zero means every out-of-window sample fires
  always_comb begin
    next_prox_cnt = prox_cnt;
    if (prox_valid_in) begin
      if (!prox_out) begin
        next_prox_cnt = 4'h0;
      end else if (prox_cnt != 4'hF) begin
        next_prox_cnt = prox_cnt + 4'h1;
      end
    end
    next_light_cnt = light_cnt;
    if (light_valid_in) begin
      if (!light_out_of_range_in) begin
        next_light_cnt = 4'h0;
      end else if (light_cnt != 4'hF) begin
        next_light_cnt = light_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      prox_cnt <= 4'h0;
      light_cnt <= 4'h0;
    end else begin
      prox_cnt <= next_prox_cnt;
      light_cnt <= next_light_cnt;
    end
  end

  // Sticky interrupts; a new event wins over a clear
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      proximity_irq_out <= 1'b0;
    end else if (prox_valid_in && prox_out && next_prox_cnt
                 >= interrupt_persistence[ipr_pkg::PROX_INTERRUPT_PERSISTENCE_MSB:ipr_pkg::PROX_INTERRUPT_PERSISTENCE_LSB]) begin
      proximity_irq_out <= 1'b1;
    end else if (clear_proximity_irq_in) begin
      proximity_irq_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      light_irq_out <= 1'b0;
    end else if (light_valid_in && light_out_of_range_in && next_light_cnt
                 >= interrupt_persistence[ipr_pkg::LIGHT_INTERRUPT_PERSISTENCE_MSB:ipr_pkg::LIGHT_INTERRUPT_PERSISTENCE_LSB]) begin
      light_irq_out <= 1'b1;
    end else if (clear_light_irq_in) begin
      light_irq_out <= 1'b0;
    end
  end

  ipr_pin_mux u_irq_mux (
    .sel_in(pin_source_select[ipr_pkg::IRQ_SEL_MSB:ipr_pkg::IRQ_SEL_LSB]),
    .src_in(src),
    .normal_in(normal_irq),
    .assert_out(irq_assert)
  );

  ipr_pin_mux u_aux_mux (
    .sel_in(pin_source_select[ipr_pkg::AUX_SEL_MSB:ipr_pkg::AUX_SEL_LSB]),
    .src_in(src),
    .normal_in(normal_irq),
    .assert_out(aux_assert)
  );

  // Pins; interrupt pin active low
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      irq_pin_n_out <= 1'b1;
      aux_pin_out <= 1'b0;
    end else begin
      irq_pin_n_out <= !irq_assert;
      aux_pin_out <= aux_assert;
    end
  end

  // Sleep flag: set while pin low with sleep enabled; set wins over clear
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sleep_after_irq_flag_out <= 1'b0;
    end else if (sleep_after_irq && !irq_pin_n_out) begin
      sleep_after_irq_flag_out <= 1'b1;
    end else if (clear_sleep_flag_in) begin
      sleep_after_irq_flag_out <= 1'b0;
    end
  end

  // With sleep_after_irq set the oscillator runs only when the flag is clear and the pin released
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      osc_enable_out <= 1'b1;
    end else begin
      osc_enable_out <= !(sleep_after_irq && (!irq_pin_n_out
                         || sleep_after_irq_flag_out));
    end
  end
endmodule : ipr_core

// file: hw/ipr_pin_mux.sv
`timescale 1ns/100ps
// Selects the level for one pin; all sources are active high internally
module ipr_pin_mux (
  // Select and sources
  input wire logic [3:0] sel_in,
  input wire ipr_pkg::ipr_irq_src_s src_in,
  input wire logic normal_in,
  // Active-high assertion request for the pin
  output logic assert_out
);
  always_comb begin
    case (sel_in)
      ipr_pkg::PIN_NORMAL: assert_out = normal_in;
      ipr_pkg::PIN_LIGHT_DIRECT: assert_out = src_in.light_irq;
      ipr_pkg::PIN_PROX_DIRECT: assert_out = src_in.proximity_irq;
      ipr_pkg::PIN_INVERTED_A: assert_out = !normal_in;
      ipr_pkg::PIN_INVERTED_B: assert_out = !normal_in;
      ipr_pkg::PIN_EMITTER: assert_out = src_in.emitter_pulse;
      default: assert_out = 1'b0;
    endcase
  end
endmodule : ipr_pin_mux

// file: hw/ipr_pkg.sv
package ipr_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_CONFIG_SLEEP_CROSSTALK = 8'h96;
  localparam logic [7:0] ADDR_PIN_SOURCE_SELECT = 8'h97;
  localparam logic [7:0] ADDR_INTERRUPT_PERSISTENCE = 8'h9A;
  // Field positions
  localparam int HIGH_XTALK_A_BIT = 5;
  localparam int SLEEP_AFTER_IRQ_BIT = 4;
  localparam int IRQ_SEL_MSB = 7;
  localparam int IRQ_SEL_LSB = 4;
  localparam int AUX_SEL_MSB = 3;
  localparam int AUX_SEL_LSB = 0;
  localparam int PROX_INTERRUPT_PERSISTENCE_MSB = 7;
  localparam int PROX_INTERRUPT_PERSISTENCE_LSB = 4;
  localparam int LIGHT_INTERRUPT_PERSISTENCE_MSB = 3;
  localparam int LIGHT_INTERRUPT_PERSISTENCE_LSB = 0;
  // Reset values and writable-bit mask
  localparam logic [7:0] RST_CONFIG_SLEEP_CROSSTALK = 8'h0F;
  localparam logic [7:0] RST_PIN_SOURCE_SELECT = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_PERSISTENCE = 8'h00;
  localparam logic [7:0] CONFIG_SLEEP_CROSSTALK_RW_MASK = 8'h30;
  // Pin source codes
  localparam logic [3:0] PIN_NORMAL = 4'h0;
  localparam logic [3:0] PIN_LIGHT_DIRECT = 4'h2;
  localparam logic [3:0] PIN_PROX_DIRECT = 4'h3;
  localparam logic [3:0] PIN_INVERTED_A = 4'h4;
  localparam logic [3:0] PIN_INVERTED_B = 4'h5;
  localparam logic [3:0] PIN_EMITTER = 4'h6;
  localparam int RESULT_W = 16;
  localparam int XTALK_RESULT_W = 10;
  localparam int INTERRUPT_PERSISTENCE_CNT_W = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ipr_reg_req_s;

  typedef struct packed {
    logic light_irq;
    logic proximity_irq;
    logic emitter_pulse;
  } ipr_irq_src_s;
endpackage : ipr_pkg

// file: testbench/interrupt_pin_routing_config_test.sv
`timescale 1ns/100ps
module interrupt_pin_routing_config_test;
  logic clk_sys_in = 0, srst_in = 1, xb = 0, pv = 0, lv = 0, lo = 0, em = 0, svc = 0;
  logic [15:0] pr = 16'h0000;
  logic [15:0] pres;
  logic [7:0] rdata;
  logic li, pi, pin_n, aux, osc, flag, clr_i, clr_s;
  ipr_pkg::ipr_reg_req_s req = '0;
  int miscompares = 0, checks_done = 0;
  ipr_core u_ipr_core (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .high_xtalk_enable_b_in(xb), .prox_valid_in(pv),
    .proximity_result_in(pr), .proximity_low_threshold_in(16'h0100),
    .proximity_high_threshold_in(16'hF000), .light_valid_in(lv), .light_out_of_range_in(lo),
    .clear_light_irq_in(clr_i), .clear_proximity_irq_in(clr_i), .clear_sleep_flag_in(clr_s),
    .emitter_pulse_in(em), .proximity_result_out(pres), .light_irq_out(li),
    .proximity_irq_out(pi), .irq_pin_n_out(pin_n), .aux_pin_out(aux), .osc_enable_out(osc),
    .sleep_after_irq_flag_out(flag));
  ipr_host_model u_ipr_host_model (.clk_sys_in(clk_sys_in), .service_in(svc),
    .irq_pin_n_in(pin_n), .flag_in(flag), .clear_irq_out(clr_i), .clear_sleep_out(clr_s));
  initial begin
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    tick(1);
    req = '0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    req = '{1'b0, 1'b1, a, 8'h00};
    tick(1);
    req = '0;
    tick(1);
    chk({8'h00, rdata}, {8'h00, e});
  endtask : rd
  // Same code on both pins; e is the expected active state of the pins
  task automatic pin_chk(input logic [3:0] code, input logic e);
    wr(8'h97, {code, code});
    tick(1);
    chk(pin_n, !e);
    chk(aux, e);
  endtask : pin_chk
  task automatic smp(input logic [15:0] v);
    pr = v;
    pv = 1;
    tick(1);
    pv = 0;
    tick(1);
  endtask : smp
  task automatic end_sim;
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  initial begin
    tick(16);
    srst_in = 0;
    rd(8'h96, 8'h0F);
    rd(8'h97, 8'h00);
    rd(8'h9A, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'hEF, 8'h00);
    wr(8'h96, 8'h2F);
    rd(8'h96, 8'h2F);
    smp(16'hE405);
    chk(pres, 16'hE405);
    xb = 1;
    smp(16'hE405);
    chk(pres, 16'h0005);
    wr(8'h9A, 8'h30);
    smp(16'h0050);
    smp(16'h0050);
    smp(16'h0800);
    smp(16'h0050);
    smp(16'h0050);
    chk(pi, 0);
    smp(16'h0050);
    chk(pi, 1);
    // Proximity pending, light clear, emitter idle; reserved codes are never written
    pin_chk(4'h0, 1'b1);
    pin_chk(4'h2, 1'b0);
    pin_chk(4'h3, 1'b1);
    pin_chk(4'h4, 1'b0);
    pin_chk(4'h5, 1'b0);
    pin_chk(4'h6, 1'b0);
    lo = 1;
    lv = 1;
    tick(1);
    lv = 0;
    chk(li, 1);
    em = 1;
    pin_chk(4'h0, 1'b1);
    pin_chk(4'h2, 1'b1);
    pin_chk(4'h3, 1'b1);
    pin_chk(4'h4, 1'b0);
    pin_chk(4'h5, 1'b0);
    pin_chk(4'h6, 1'b1);
    wr(8'h97, 8'h00);
    wr(8'h96, 8'h1F);
    tick(2);
    chk(flag, 1);
    chk(osc, 0);
    svc = 1;
    for (int i = 0; i < 20 && osc !== 1'b1; i++) tick(1);
    chk(osc, 1);
    chk(flag, 0);
    // First crosstalk enable now clear: second enable alone leaves the result whole
    smp(16'hE405);
    chk(pres, 16'hE405);
    srst_in = 1;
    tick(2);
    chk(pres, 16'h0000);
    chk(pin_n, 1);
    chk(aux, 0);
    chk(osc, 1);
    chk(flag, 0);
    chk({li, pi}, 2'b00);
    srst_in = 0;
    rd(8'h96, 8'h0F);
    rd(8'h97, 8'h00);
    end_sim();
  end
endmodule : interrupt_pin_routing_config_test

// file: testbench/ipr_chk.sv
`timescale 1ns/100ps
module ipr_chk (
  // Watched ports
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic high_xtalk_enable_b_in,
  input wire logic prox_valid_in,
  input wire logic [ipr_pkg::RESULT_W-1:0] proximity_result_in,
  input wire logic [ipr_pkg::RESULT_W-1:0] proximity_low_threshold_in,
  input wire logic [ipr_pkg::RESULT_W-1:0] proximity_high_threshold_in,
  input wire logic light_valid_in,
  input wire logic light_out_of_range_in,
  input wire logic clear_light_irq_in,
  input wire logic clear_proximity_irq_in,
  input wire logic clear_sleep_flag_in,
  input wire logic [ipr_pkg::RESULT_W-1:0] proximity_result_out,
  input wire logic light_irq_out,
  input wire logic proximity_irq_out,
  input wire logic irq_pin_n_out,
  input wire logic osc_enable_out,
  input wire logic sleep_after_irq_flag_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  sequence s_in_window;
    prox_valid_in && proximity_result_in >= proximity_low_threshold_in &&
      proximity_result_in <= proximity_high_threshold_in;
  endsequence
  property p_stop;
    $rose(sleep_after_irq_flag_out) |-> !$past(irq_pin_n_out) && !osc_enable_out;
  endproperty
  property p_flag; $fell(osc_enable_out) |-> $rose(sleep_after_irq_flag_out); endproperty
  property p_wake;
    $rose(osc_enable_out) |-> $past(irq_pin_n_out) && !$past(sleep_after_irq_flag_out);
  endproperty
  property p_flag_clr;
    $fell(sleep_after_irq_flag_out) |-> $past(clear_sleep_flag_in && irq_pin_n_out);
  endproperty
  property p_full;
    $past(prox_valid_in && !high_xtalk_enable_b_in)
      |-> proximity_result_out == $past(proximity_result_in);
  endproperty
  property p_in_clr; s_in_window |=> !$rose(proximity_irq_out); endproperty
  property p_prox_set; $rose(proximity_irq_out) |-> $past(prox_valid_in); endproperty
  property p_light_set;
    $rose(light_irq_out) |-> $past(light_valid_in && light_out_of_range_in);
  endproperty
  property p_sticky;
    $fell(proximity_irq_out) || $fell(light_irq_out)
      |-> $past(clear_proximity_irq_in || clear_light_irq_in);
  endproperty
  a_stop: assert property (p_stop) else $error("oscillator not stopped");
  a_flag: assert property (p_flag) else $error("stop without flag");
  a_wake: assert property (p_wake) else $error("early wake");
  a_flag_clr: assert property (p_flag_clr) else $error("flag cleared wrongly");
  a_full: assert property (p_full) else $error("result cut without both enables");
  a_in_clr: assert property (p_in_clr) else $error("in-window sample raised irq");
  a_prox_set: assert property (p_prox_set) else $error("prox irq without sample");
  a_light_set: assert property (p_light_set) else $error("light irq without sample");
  a_sticky: assert property (p_sticky) else $error("irq dropped without clear");
endmodule : ipr_chk
bind ipr_core ipr_chk u_ipr_chk (.clk_sys_in, .srst_in, .high_xtalk_enable_b_in, .prox_valid_in,
  .proximity_result_in, .proximity_low_threshold_in, .proximity_high_threshold_in,
  .light_valid_in, .light_out_of_range_in, .clear_light_irq_in, .clear_proximity_irq_in,
  .clear_sleep_flag_in, .proximity_result_out, .light_irq_out, .proximity_irq_out,
  .irq_pin_n_out, .osc_enable_out, .sleep_after_irq_flag_out);

// file: testbench/ipr_host_model.sv
`timescale 1ns/100ps
// Host that services the interrupt pin while enabled
module ipr_host_model (
  // Clock and status
  input wire logic clk_sys_in,
  input wire logic service_in,
  input wire logic irq_pin_n_in,
  input wire logic flag_in,
  // Clear pulses
  output logic clear_irq_out,
  output logic clear_sleep_out
);
  always_ff @(posedge clk_sys_in) begin
    clear_irq_out <= service_in && !irq_pin_n_in && !clear_irq_out;
    clear_sleep_out <= service_in && irq_pin_n_in && flag_in && !clear_sleep_out;
  end
endmodule : ipr_host_model
